// [tmz_regs.svh]
// tmz_regs.svh: register offsets, field positions, reset values and timing counts
// assumes: included by the timer design file, the checker and the bench
`ifndef TMZ_REGS_SVH
`define TMZ_REGS_SVH

`define TMZ_OFF_COUNT     12'h000
`define TMZ_OFF_INTCTL    12'h004
`define TMZ_OFF_OPTION    12'h008
`define TMZ_OFF_PORTADIR  12'h00c
`define TMZ_OFF_CONTROL   12'h010
`define TMZ_OFF_IRQ_STAT  12'h014
`define TMZ_OFF_IRQ_MASK  12'h018

// option_config fields
`define TMZ_OPT_SRC_BIT   5
`define TMZ_OPT_EDGE_BIT  4
`define TMZ_OPT_PSA_BIT   3
`define TMZ_OPT_PS_LSB    0
// interrupt_control fields
`define TMZ_INT_GIE_BIT   7
`define TMZ_INT_TIMER_OVERFLOW_IRQ_ENABLE_BIT  5
`define TMZ_INT_TIMER_OVERFLOW_FLAG_BIT  2
// control register fields (write-one actions and sleep level)
`define TMZ_CTL_WDCLR_BIT 0
`define TMZ_CTL_SLEEP_BIT 1

`define TMZ_RST_OPTION    8'hff
`define TMZ_RST_PORTADIR  8'h1f
`define TMZ_RST_COUNT     8'h00
`define TMZ_RST_INTCTL    8'h00
`define TMZ_PORTADIR_MASK 8'h1f

// internal phase clock: four system clocks per instruction cycle
`define TMZ_PHASES        2'h3
// watchdog timeout in watchdog ticks, prescaled only when the prescaler serves the watchdog, else instruction cycles (arbitrary plain default)
`define TMZ_WDT_LIMIT     8'hff

`endif

// [tmz_pkg.sv]
// tmz_pkg.sv: types shared by the timer block
// assumes: tmz_regs.svh is on the include path
package tmz_pkg;

  typedef struct packed {
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hsel;
    logic        hready;
    logic [31:0] hwdata;
  } tmz_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } tmz_ahb_rsp_t;

  typedef enum logic [1:0] {
    TMZ_Q1 = 2'b00,
    TMZ_Q2 = 2'b01,
    TMZ_Q3 = 2'b10,
    TMZ_Q4 = 2'b11
  } tmz_phase_t;

endpackage : tmz_pkg

// [tmz_timer.sv]
// tmz_timer.sv: 8-bit timer with prescaler shared with the watchdog, AHB-Lite slave
// assumes: one clock sys_clk, synchronous active-high reset, counter pin asynchronous
// Operation
// - one prescaler, timer when assign bit 0
// - three-bit ratio chooses 1:2 to 1:256
// - 1:1 only when prescaler serves watchdog
// - prescaler count is not software visible
// - timer count write clears prescaler when it is assigned to the timer
// - watchdog clear clears watchdog, and prescaler when it is assigned to the watchdog
// - FFh to 00h rollover is the event
// - flag sets on rollover regardless of enable
// - only software clears the overflow flag
// - enable bit gates timer_irq; irq is gated by irq_mask_reg instead
// - timer frozen during sleep
// - external clock sampled on second, fourth phase
//
// The placing of the registers and the AHB-Lite register port were decided locally.
`include "tmz_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module tmz_timer
(
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  input  wire tmz_pkg::tmz_ahb_req_t ahb_req,
  output var  tmz_pkg::tmz_ahb_rsp_t ahb_rsp,
  input  wire logic                  counter_clock_input_pin,
  output logic                       timer_irq,
  output logic                       irq,
  output logic                       watchdog_timeout
);
  import tmz_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]  count_reg,     count_next;
  logic [7:0]  intctl_reg,    intctl_next;
  logic [7:0]  option_reg,    option_next;
  logic [7:0]  portadir_reg,  portadir_next;
  logic        sleep_reg;
  logic [7:0]  prescale_reg,  prescale_next;
  logic [7:0]  wdt_reg,       wdt_next;
  logic        wdt_to_reg;
  logic [1:0]  irq_stat_reg,  irq_stat_next;
  logic [1:0]  irq_mask_reg;
  tmz_phase_t  phase_reg;
  logic        pin_s1_reg,    pin_s2_reg,  pin_d_reg;
  logic        ext_samp_reg,  ext_prev_reg;
  logic        wdt_tick_reg;
  logic        wr_pend_reg;
  logic [11:0] wr_addr_reg;
  logic [31:0] hrdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire        bus_take  = ahb_req.hsel & ahb_req.hready & ahb_req.htrans[1];
  wire        wr_take   = bus_take & ahb_req.hwrite;
  wire        rd_take   = bus_take & ~ahb_req.hwrite;
  wire [7:0]  wdat      = ahb_req.hwdata[7:0];
  // read data is registered at the address phase so it stands in the data phase
  wire [11:0] rd_sel    = {ahb_req.haddr[11:2], 2'b00};
  wire        wr_count  = wr_pend_reg & (wr_addr_reg == `TMZ_OFF_COUNT);
  wire        wr_intctl = wr_pend_reg & (wr_addr_reg == `TMZ_OFF_INTCTL);
  wire        wr_option = wr_pend_reg & (wr_addr_reg == `TMZ_OFF_OPTION);
  wire        wr_pdir   = wr_pend_reg & (wr_addr_reg == `TMZ_OFF_PORTADIR);
  wire        wr_ctl    = wr_pend_reg & (wr_addr_reg == `TMZ_OFF_CONTROL);
  wire        wr_stat   = wr_pend_reg & (wr_addr_reg == `TMZ_OFF_IRQ_STAT);
  wire        wr_mask   = wr_pend_reg & (wr_addr_reg == `TMZ_OFF_IRQ_MASK);
  wire        wdt_clear = wr_ctl & wdat[`TMZ_CTL_WDCLR_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // clock source selection and prescaler
  wire        psa_wdt    = option_reg[`TMZ_OPT_PSA_BIT];
  wire [2:0]  ps_sel     = option_reg[`TMZ_OPT_PS_LSB +: 3];
  wire        src_ext    = option_reg[`TMZ_OPT_SRC_BIT];
  wire        edge_fall  = option_reg[`TMZ_OPT_EDGE_BIT];
  wire        instr_tick = (phase_reg == TMZ_Q4);
  wire        pin_lvl    = pin_d_reg ^ edge_fall;
  wire        pin_rise   = pin_lvl & ~ext_prev_reg;
  wire        raw_tick   = src_ext ? pin_rise : instr_tick;
  // the watchdog ticks on the instruction clock in this model
  wire        pre_in     = psa_wdt ? instr_tick : raw_tick;
  // ratio 1:2^(ps+1) when assigned to the timer
  wire [7:0]  pre_mask   = 8'((9'h002 << ps_sel) - 9'h001);
  wire        pre_wrap   = pre_in & ((prescale_reg & pre_mask) == pre_mask);
  wire        pre_clr    = (wr_count & ~psa_wdt)
                         | (wdt_clear & psa_wdt);
  // undivided only when the prescaler serves the watchdog
  wire        tmr_src    = psa_wdt ? raw_tick : pre_wrap;
  wire        wdt_in     = psa_wdt ? pre_wrap : instr_tick;
  wire        phase_samp = (phase_reg == TMZ_Q2) | (phase_reg == TMZ_Q4);
  // external path: prescaler output resampled on the second and fourth phases
  wire        tmr_tick   = src_ext ? (ext_samp_reg & ~wdt_tick_reg) : tmr_src;

  always_comb
  begin
    prescale_next = prescale_reg;
    if (pre_clr)
      prescale_next = 8'h00;
    else if (pre_in)
      prescale_next = prescale_reg + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter and flag
  wire        count_inc = tmr_tick & ~sleep_reg;
  wire        rollover  = count_inc & (count_reg == 8'hff);

  always_comb
  begin
    count_next = count_reg;
    if (wr_count)
      count_next = wdat;
    else if (count_inc)
      count_next = count_reg + 8'h01;
  end

  always_comb
  begin
    intctl_next = intctl_reg;
    if (wr_intctl)
      intctl_next = wdat;
    // set wins over a same-cycle software clear
    if (rollover)
      intctl_next[`TMZ_INT_TIMER_OVERFLOW_FLAG_BIT] = 1'b1;
  end

  always_comb
  begin
    irq_stat_next = irq_stat_reg;
    if (wr_stat)
      irq_stat_next = irq_stat_reg & ~wdat[1:0];
    irq_stat_next = irq_stat_next | {watchdog_timeout & ~wdt_to_reg, rollover};
  end

  always_comb
  begin
    wdt_next = wdt_reg;
    if (wdt_clear)
      wdt_next = 8'h00;
    else if (wdt_in & ~watchdog_timeout)
      wdt_next = wdt_reg + 8'h01;
  end

  wire timer_overflow_flag = intctl_reg[`TMZ_INT_TIMER_OVERFLOW_FLAG_BIT];
  wire timer_overflow_irq_enable = intctl_reg[`TMZ_INT_TIMER_OVERFLOW_IRQ_ENABLE_BIT];
  assign timer_irq        = timer_overflow_flag & timer_overflow_irq_enable;
  assign irq              = |(irq_stat_reg & irq_mask_reg);
  assign watchdog_timeout = (wdt_reg == `TMZ_WDT_LIMIT);

  ////////////////////////////////////////////////////////////////////////////
  // register read mux; the prescaler count has no address
  logic [7:0] rd_byte;
  always_comb
  begin
    rd_byte = 8'h00;
    unique case (rd_sel)
      `TMZ_OFF_COUNT:    rd_byte = count_reg;
      `TMZ_OFF_INTCTL:   rd_byte = intctl_reg;
      `TMZ_OFF_OPTION:   rd_byte = option_reg;
      `TMZ_OFF_PORTADIR: rd_byte = portadir_reg;
      `TMZ_OFF_CONTROL:  rd_byte = {6'h00, sleep_reg, 1'b0};
      `TMZ_OFF_IRQ_STAT: rd_byte = {6'h00, irq_stat_reg};
      `TMZ_OFF_IRQ_MASK: rd_byte = {6'h00, irq_mask_reg};
      default:           rd_byte = 8'h00;
    endcase
  end

  assign ahb_rsp.hrdata    = hrdata_reg;
  assign ahb_rsp.hreadyout = 1'b1;
  assign ahb_rsp.hresp     = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // flops
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      pin_s1_reg   <= 1'b0;
      pin_s2_reg   <= 1'b0;
      pin_d_reg    <= 1'b0;
      ext_prev_reg <= 1'b0;
      ext_samp_reg <= 1'b0;
      wdt_tick_reg <= 1'b0;
      phase_reg    <= TMZ_Q1;
    end
    else
    begin
      pin_s1_reg   <= counter_clock_input_pin;
      pin_s2_reg   <= pin_s1_reg;
      pin_d_reg    <= pin_s2_reg;
      ext_prev_reg <= pin_lvl;
      phase_reg    <= tmz_phase_t'(phase_reg + 2'h1);
      // latch the prescaler output until the next sampling phase
      if (phase_samp)
      begin
        ext_samp_reg <= tmr_src | (wdt_tick_reg & ~ext_samp_reg);
        wdt_tick_reg <= 1'b0;
      end
      else if (tmr_src)
        wdt_tick_reg <= 1'b1;
      else
        ext_samp_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      count_reg    <= `TMZ_RST_COUNT;
      intctl_reg   <= `TMZ_RST_INTCTL;
      option_reg   <= `TMZ_RST_OPTION;
      portadir_reg <= `TMZ_RST_PORTADIR;
      sleep_reg    <= 1'b0;
      prescale_reg <= 8'h00;
      wdt_reg      <= 8'h00;
      wdt_to_reg   <= 1'b0;
      irq_stat_reg <= 2'h0;
      irq_mask_reg <= 2'h0;
    end
    else
    begin
      count_reg    <= count_next;
      intctl_reg   <= intctl_next;
      prescale_reg <= prescale_next;
      wdt_reg      <= wdt_next;
      wdt_to_reg   <= watchdog_timeout;
      irq_stat_reg <= irq_stat_next;
      if (wr_option)
        option_reg <= wdat;
      if (wr_pdir)
        portadir_reg <= wdat & `TMZ_PORTADIR_MASK;
      if (wr_ctl)
        sleep_reg <= wdat[`TMZ_CTL_SLEEP_BIT];
      if (wr_mask)
        irq_mask_reg <= wdat[1:0];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
      hrdata_reg  <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_reg <= wr_take;
      if (wr_take)
        wr_addr_reg <= {ahb_req.haddr[11:2], 2'b00};
      if (rd_take)
        hrdata_reg <= {24'h000000, rd_byte};
    end
  end

endmodule : tmz_timer

`default_nettype wire

// [tmz_timer_checker.sv]
// tmz_timer_checker.sv: port assertions for the timer block
// assumes: bound into tmz_timer; one clock, synchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
`include "tmz_regs.svh"
module tmz_timer_checker
(
  input wire logic                  sys_clk,
  input wire logic                  reset,
  input wire tmz_pkg::tmz_ahb_req_t ahb_req,
  input wire tmz_pkg::tmz_ahb_rsp_t ahb_rsp,
  input wire logic                  timer_irq,
  input wire logic                  irq,
  input wire logic                  watchdog_timeout
);
  import tmz_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire logic tk = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];
  wire logic rd = tk && !ahb_req.hwrite;
  wire logic wi = tk && ahb_req.hwrite && ahb_req.haddr == `TMZ_OFF_INTCTL;
  wire logic wm = tk && ahb_req.hwrite && ahb_req.haddr == `TMZ_OFF_IRQ_MASK;
  wire logic wq = wm || tk && ahb_req.hwrite && ahb_req.haddr == `TMZ_OFF_IRQ_STAT;
  wire logic wc = tk && ahb_req.hwrite && ahb_req.haddr == `TMZ_OFF_CONTROL;
  ////////////////////////////////////////
  AST_BUS_OKAY: assert property ((ahb_rsp.hreadyout && !ahb_rsp.hresp) [*2])
    else $error("bus not ready or not okay");
  AST_RD_HIGH_ZERO: assert property (rd |-> ##1 ahb_rsp.hrdata[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_RD_UNMAPPED: assert property
    (rd && ahb_req.haddr > `TMZ_OFF_IRQ_MASK |-> ##1 !ahb_rsp.hrdata) else $error("unmapped read");
  AST_FLAG_STICKY: assert property
    ($fell(timer_irq) |-> $past(wi, 2) || $past(wi, 3)) else $error("flag cleared alone");
  AST_STAT_STICKY: assert property
    ($fell(irq) |-> $past(wq, 2) || $past(wq, 3)) else $error("irq dropped alone");
  AST_WDT_HOLD: assert property
    ($fell(watchdog_timeout) |-> $past(wc, 2) || $past(wc, 3)) else $error("timeout dropped");
  AST_ENABLE_GATES: assert property
    (wi ##1 !ahb_req.hwdata[5] |-> ##2 !timer_irq) else $error("irq while disabled");
  AST_MASK_GATES: assert property
    (wm ##1 !ahb_req.hwdata[7:0] |-> ##2 !irq) else $error("irq while masked");
  cover property (rd);
  cover property ($rose(timer_irq));
  cover property ($rose(irq));
endmodule : tmz_timer_checker
bind tmz_timer tmz_timer_checker u_chk (.sys_clk(sys_clk), .reset(reset), .ahb_req(ahb_req),
  .ahb_rsp(ahb_rsp), .timer_irq(timer_irq), .irq(irq), .watchdog_timeout(watchdog_timeout));
`default_nettype wire

// [tmz_ext_clk.sv]
// tmz_ext_clk.sv: count clock source for the external input pin
// assumes: stepped by the bench clock; rests low while not running
`timescale 1ns/1ns
`default_nettype none
module tmz_ext_clk
(
  input  wire logic       sys_clk,
  input  wire logic       run,
  input  wire logic [3:0] half_cycles,
  output var  logic       pin
);
  logic [3:0] cnt_reg = 4'h0;
  initial pin = 1'b0;
  // each level lasts half_cycles clocks, long enough for both phase samples
  always @(posedge sys_clk)
  begin
    cnt_reg <= (!run || cnt_reg + 4'h1 >= half_cycles) ? 4'h0 : cnt_reg + 4'h1;
    pin     <= run && (cnt_reg + 4'h1 >= half_cycles ? !pin : pin);
  end
endmodule : tmz_ext_clk
`default_nettype wire

// [tmz_timer_tb.sv]
// tmz_timer_tb.sv: self-checking bench for the timer block
// assumes: package, register header, clock source and checker compiled first
`timescale 1ns/1ns
`default_nettype none
`include "tmz_regs.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %0t got %h want %h", $time, g, e); end end
module tmz_timer_tb;
  import tmz_pkg::*;
  localparam logic [11:0] CNT = `TMZ_OFF_COUNT, ICT = `TMZ_OFF_INTCTL, OPT = `TMZ_OFF_OPTION;
  localparam logic [11:0] CTL = `TMZ_OFF_CONTROL, MSK = `TMZ_OFF_IRQ_MASK;
  logic         sys_clk, reset, ext_run, ext_pin, timer_irq, irq, wdt;
  logic [3:0]   ext_half;
  logic [7:0]   a;
  logic [31:0]  rd;
  tmz_ahb_req_t req, bus_req;
  tmz_ahb_rsp_t rsp;
  int           errors, samples_checked, seed, edges, k;
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always_comb
  begin
    bus_req        = req;
    bus_req.hready = rsp.hreadyout;
  end
  always @(posedge ext_pin) edges++;
  tmz_timer u_dut (.sys_clk(sys_clk), .reset(reset), .ahb_req(bus_req), .ahb_rsp(rsp),
    .counter_clock_input_pin(ext_pin), .timer_irq(timer_irq), .irq(irq),
    .watchdog_timeout(wdt));
  tmz_ext_clk u_src (.sys_clk(sys_clk), .run(ext_run), .half_cycles(ext_half), .pin(ext_pin));
  task automatic tally_and_finish;
    if (errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  // one edge, then more while the slave stretches, bounded
  task automatic step;
    int n;
    n = 0;
    do @(posedge sys_clk) n++; while (rsp.hreadyout !== 1'b1 && n < 40);
    if (n >= 40)
    begin
      `CHK(n, 0)
      tally_and_finish;
    end
  endtask : step
  // read data stands in the data phase and is taken at its closing edge
  task automatic xfer(input logic [11:0] adr, input logic wr, input logic [7:0] dat);
    @(posedge sys_clk);
    req.haddr  <= adr;
    req.hwrite <= wr;
    req.htrans <= 2'b10;
    step;
    req.htrans <= 2'b00;
    req.hwdata <= {24'h0, dat};
    step;
    rd = rsp.hrdata;
    #1;
  endtask : xfer
  task automatic rdc(input logic [11:0] adr, input logic [31:0] want);
    xfer(adr, 1'b0, 8'h00);
    `CHK(rd, want)
  endtask : rdc
  initial
  begin
    seed = 94;
    errors = 0;
    samples_checked = 0;
    edges = 0;
    reset = 1'b1;
    req = '0;
    req.hsel = 1'b1;
    req.hsize = 3'b010;
    ext_run = 1'b0;
    ext_half = 4'h4;
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    rdc(CNT, 32'h00);
    rdc(ICT, 32'h00);
    rdc(OPT, 32'hff);
    xfer(`TMZ_OFF_PORTADIR, 1'b1, 8'hff);
    rdc(`TMZ_OFF_PORTADIR, 32'h1f);
    rdc(12'h01c, 32'h00);
    xfer(CTL, 1'b1, 8'h01);
    for (k = 0; k < 8; k++)
    begin
      xfer(OPT, 1'b1, 8'(k));
      xfer(CNT, 1'b1, 8'h00);
      repeat (24 << k) @(posedge sys_clk);
      xfer(CNT, 1'b0, 8'h00);
      `CHK(8'(rd[7:0] - 8'h02) < 8'h03, 1'b1)
    end
    xfer(CTL, 1'b1, 8'h01);
    xfer(CNT, 1'b1, 8'h00);
    xfer(OPT, 1'b1, 8'h08);
    xfer(CTL, 1'b1, 8'h01);
    `CHK(wdt, 1'b0)
    a = 8'($random(seed));
    xfer(CNT, 1'b1, a);
    repeat (40) @(posedge sys_clk);
    xfer(CNT, 1'b0, 8'h00);
    `CHK(8'(rd[7:0] - a - 8'h0a) < 8'h03, 1'b1)
    xfer(ICT, 1'b1, 8'h00);
    xfer(CNT, 1'b1, 8'hfe);
    repeat (20) @(posedge sys_clk);
    rdc(ICT, 32'h04);
    `CHK(timer_irq, 1'b0)
    xfer(CTL, 1'b1, 8'h02);
    xfer(CNT, 1'b0, 8'h00);
    a = rd[7:0];
    repeat (300) @(posedge sys_clk);
    rdc(CNT, {24'h0, a});
    rdc(ICT, 32'h04);
    xfer(ICT, 1'b1, 8'h24);
    `CHK(timer_irq, 1'b1)
    xfer(MSK, 1'b1, 8'h01);
    `CHK(irq, 1'b1)
    xfer(MSK, 1'b1, 8'h00);
    `CHK(irq, 1'b0)
    xfer(`TMZ_OFF_IRQ_STAT, 1'b1, 8'h01);
    xfer(MSK, 1'b1, 8'h01);
    `CHK(irq, 1'b0)
    xfer(ICT, 1'b1, 8'h20);
    `CHK(timer_irq, 1'b0)
    xfer(CTL, 1'b1, 8'h01);
    for (k = 0; k < 2; k++)
    begin
      xfer(OPT, 1'b1, 8'h28);
      xfer(CNT, 1'b1, 8'h00);
      edges = 0;
      ext_half <= 4'h4 + 4'({$random(seed)} % 8);
      ext_run <= 1'b1;
      repeat (200) @(posedge sys_clk);
      ext_run <= 1'b0;
      repeat (10) @(posedge sys_clk);
      xfer(CNT, 1'b0, 8'h00);
      `CHK(rd, 32'(edges))
    end
    tally_and_finish;
  end
endmodule : tmz_timer_tb
`default_nettype wire
